// ---- verification/etc_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
	import etc_pkg::*;
	logic       core_clk;    // 40 MHz core clock
	logic       rst_n;       // synchronous reset, active low
	etc_bus_t   bus;         // register port request
	logic [7:0] rdata;       // read data from the core
	logic       presc_tick;  // prescaler tick pulse
	logic       ext_clk_pin; // external count pin
	logic       irq_ack_ovf; // overflow service pulse
	logic       irq_ack_ca;  // compare a service pulse
	logic       irq_ack_cb;  // compare b service pulse
	logic [1:0] port_data;   // general port values
	logic       irq_ovf;     // overflow request
	logic       irq_ca;      // compare a request
	logic       irq_cb;      // compare b request
	logic [1:0] pin_out;     // pin values
	logic [1:0] pin_oe;      // pin drive enables
	int         fail_count;  // mismatches seen
	int         n_tests;     // comparisons made

	etc_core uut (
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.bus         (bus),
		.rdata       (rdata),
		.presc_tick  (presc_tick),
		.ext_clk_pin (ext_clk_pin),
		.irq_ack_ovf (irq_ack_ovf),
		.irq_ack_ca  (irq_ack_ca),
		.irq_ack_cb  (irq_ack_cb),
		.port_data   (port_data),
		.irq_ovf     (irq_ovf),
		.irq_ca      (irq_ca),
		.irq_cb      (irq_cb),
		.pin_out     (pin_out),
		.pin_oe      (pin_oe)
	);

	// free-running clock, 25 ns period
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// compare one value and count it
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// verdict and end of run
	task automatic summarize();
		if (fail_count == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		bus <= {a, d, 1'b1, 1'b0};
		@(posedge core_clk);
		bus.wr <= 1'b0;
	endtask

	// one-cycle read strobe, data checked in the cycle after
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge core_clk);
		bus.rd <= 1'b0;
		#1;
		check(rdata, exp);
	endtask

	// one prescaler tick pulse
	task automatic tick();
		@(posedge core_clk);
		presc_tick <= 1'b1;
		@(posedge core_clk);
		presc_tick <= 1'b0;
	endtask

	// let registered outputs settle
	task automatic settle();
		repeat (2) @(posedge core_clk);
		#1;
	endtask

	// watchdog against a hang
	initial begin
		#(25 * 3000);
		fail_count++;
		summarize();
	end

	// main sequence
	initial begin
		fail_count = 0;
		n_tests = 0;
		rst_n = 1'b0;
		bus = '0;
		presc_tick = 1'b0;
		ext_clk_pin = 1'b0;
		irq_ack_ovf = 1'b0;
		irq_ack_ca = 1'b0;
		irq_ack_cb = 1'b0;
		port_data = 2'b10;
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		#1;
		check({2'h0, pin_out, pin_oe, irq_ovf, irq_ca}, 8'h00);
		rd(ETC_COUNT, 8'h00);
		rd(4'hF, 8'h00);
		wr(4'hF, 8'h5A);
		rd(4'hF, 8'h00);
		// pins follow the port while output modes are zero
		wr(ETC_PINDIR, 8'h03);
		settle();
		check({6'h0, pin_oe}, 8'h03);
		check({6'h0, pin_out}, 8'h02);
		// counting on prescaler ticks
		wr(ETC_CTRL_B, 8'h02);
		wr(ETC_COUNT, 8'h10);
		repeat (3) tick();
		rd(ETC_COUNT, 8'h13);
		// counter write together with a tick
		@(posedge core_clk);
		bus <= {ETC_COUNT, 8'h80, 1'b1, 1'b0};
		presc_tick <= 1'b1;
		@(posedge core_clk);
		bus.wr <= 1'b0;
		presc_tick <= 1'b0;
		rd(ETC_COUNT, 8'h80);
		// stopped timer ignores ticks, still accessible
		wr(ETC_CTRL_B, 8'h00);
		repeat (2) tick();
		rd(ETC_COUNT, 8'h80);
		wr(ETC_COUNT, 8'h55);
		rd(ETC_COUNT, 8'h55);
		// overflow from max in normal mode
		wr(ETC_CTRL_B, 8'h02);
		wr(ETC_MASK, 8'h01);
		wr(ETC_COUNT, 8'hFF);
		tick();
		rd(ETC_COUNT, 8'h00);
		rd(ETC_FLAGS, 8'h01);
		settle();
		check({7'h0, irq_ovf}, 8'h01);
		@(posedge core_clk);
		irq_ack_ovf <= 1'b1;
		@(posedge core_clk);
		irq_ack_ovf <= 1'b0;
		settle();
		check({7'h0, irq_ovf}, 8'h00);
		rd(ETC_FLAGS, 8'h00);
		// compare flags, blocking after counter write
		port_data <= 2'b00;
		wr(ETC_CTRL_A, 8'h30);
		wr(ETC_CMP_A, 8'h20);
		wr(ETC_CMP_B, 8'h21);
		wr(ETC_COUNT, 8'h20);
		wr(ETC_FLAGS, 8'h07);
		tick();
		rd(ETC_FLAGS, 8'h00);
		check({6'h0, pin_out}, 8'h00);
		tick();
		rd(ETC_FLAGS, 8'h04);
		settle();
		check({6'h0, pin_out}, 8'h02);
		wr(ETC_COUNT, 8'h1F);
		repeat (2) tick();
		rd(ETC_FLAGS, 8'h06);
		wr(ETC_FLAGS, 8'h02);
		rd(ETC_FLAGS, 8'h04);
		wr(ETC_MASK, 8'h06);
		settle();
		check({6'h0, irq_cb, irq_ca}, 8'h02);
		@(posedge core_clk);
		irq_ack_cb <= 1'b1;
		@(posedge core_clk);
		irq_ack_cb <= 1'b0;
		rd(ETC_FLAGS, 8'h00);
		// forced compare toggles latch a only
		wr(ETC_CTRL_A, 8'h70);
		wr(ETC_FLAGS, 8'h07);
		wr(ETC_CTRL_B, 8'h82);
		settle();
		check({6'h0, pin_out}, 8'h03);
		rd(ETC_FLAGS, 8'h00);
		rd(ETC_COUNT, 8'h21);
		// latch kept over mode change, output mode acts at once
		wr(ETC_CTRL_A, 8'h72);
		settle();
		check({6'h0, pin_out}, 8'h03);
		wr(ETC_CTRL_A, 8'h32);
		settle();
		check({6'h0, pin_out}, 8'h02);
		// clear on compare match
		wr(ETC_CMP_A, 8'h05);
		wr(ETC_COUNT, 8'h04);
		repeat (2) tick();
		rd(ETC_COUNT, 8'h00);
		// fast pwm buffers the compare value
		wr(ETC_CTRL_A, 8'h33);
		wr(ETC_CMP_A, 8'h41);
		rd(ETC_CMP_A, 8'h41);
		wr(ETC_COUNT, 8'h40);
		wr(ETC_FLAGS, 8'h07);
		repeat (2) tick();
		rd(ETC_FLAGS, 8'h00);
		// external pin, rising edges only
		wr(ETC_CTRL_A, 8'h00);
		wr(ETC_COUNT, 8'h10);
		wr(ETC_CTRL_B, 8'h07);
		repeat (2) begin
			@(posedge core_clk);
			ext_clk_pin <= 1'b1;
			repeat (4) @(posedge core_clk);
			ext_clk_pin <= 1'b0;
			repeat (4) @(posedge core_clk);
		end
		rd(ETC_COUNT, 8'h12);
		// phase-correct turns at top, overflow at bottom
		wr(ETC_CTRL_B, 8'h02);
		wr(ETC_CTRL_A, 8'h01);
		wr(ETC_COUNT, 8'hFD);
		repeat (3) tick();
		rd(ETC_COUNT, 8'hFE);
		wr(ETC_COUNT, 8'h02); // nonzero while counting down
		wr(ETC_FLAGS, 8'h07);
		repeat (3) tick();
		rd(ETC_COUNT, 8'h01);
		rd(ETC_FLAGS, 8'h01);
		summarize();
	end
endmodule // tb
`default_nettype wire

// ---- verilog/etc_core.sv ----
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module etc_core
	import etc_pkg::*;
(
	input  wire logic       core_clk,     // 40 MHz core clock
	input  wire logic       rst_n,        // synchronous reset, active low
	input  wire etc_bus_t   bus,          // register port request
	output logic [7:0]      rdata,        // read data, cycle after read
	input  wire logic       presc_tick,   // prescaler tick, same domain
	input  wire logic       ext_clk_pin,  // external count pin, async
	input  wire logic       irq_ack_ovf,  // overflow interrupt serviced
	input  wire logic       irq_ack_ca,   // compare a interrupt serviced
	input  wire logic       irq_ack_cb,   // compare b interrupt serviced
	input  wire logic [1:0] port_data,    // general port output values
	output logic            irq_ovf,      // overflow interrupt request
	output logic            irq_ca,       // compare a interrupt request
	output logic            irq_cb,       // compare b interrupt request
	output logic [1:0]      pin_out,      // pin values a,b
	output logic [1:0]      pin_oe        // pin drive enables a,b
);
	// compare output action at a match
	function automatic logic com_next(input logic [1:0] com, input logic cur);
		case (com)
			ETC_COM_TOGGLE: com_next = ~cur;
			ETC_COM_CLEAR:  com_next = 1'b0;
			ETC_COM_SET:    com_next = 1'b1;
			default:        com_next = cur; // no action
		endcase
	endfunction

	logic [7:0] ctrl_a_q;             // timer_control_a
	logic [4:0] ctrl_b_q;             // timer_control_b storage bits
	logic [7:0] counter_value_q;      // counter_value
	logic [7:0] cmp_a_q, cmp_b_q;     // active compare values
	logic [7:0] buf_a_q, buf_b_q;     // compare buffers
	logic [2:0] mask_q;               // interrupt masks
	logic [2:0] flags_q;              // overflow, compare a, compare b
	logic [1:0] pindir_q;             // compare_pin_direction
	logic [1:0] latch_q;              // compare_output_latch a,b
	logic       block_q;              // match block pending
	logic       ext_s1_q, ext_s2_q;   // pin synchroniser
	logic       ext_prev_q;           // edge detector history
	etc_dir_t   dir_q;                // count direction
	logic       timer_tick;           // one-cycle tick enable
	logic [2:0] waveform_gen_mode;    // full mode field
	logic [2:0] clock_select_field;
	logic [1:0] com_a, com_b;         // compare output modes
	logic       pwm_mode, fast_mode, pc_mode;
	logic [7:0] top_val;
	logic       match_a, match_b;     // comparator outputs
	logic       at_top, at_bottom, at_max;
	logic       wr_count, wr_ca, wr_cb;
	logic       force_a, force_b;
	logic       eff_a, eff_b;         // unblocked matches on tick

	assign waveform_gen_mode  = {ctrl_b_q[ETC_WGM2_BIT], ctrl_a_q[ETC_WGM_LSB +: 2]};
	assign clock_select_field = ctrl_b_q[ETC_CS_LSB +: 3];
	assign com_a = ctrl_a_q[ETC_COMA_LSB +: 2]; // used live, unbuffered
	assign com_b = ctrl_a_q[ETC_COMB_LSB +: 2];
	assign fast_mode = (waveform_gen_mode == ETC_WGM_FPWM) || (waveform_gen_mode == ETC_WGM_FPWMA);
	assign pc_mode   = (waveform_gen_mode == ETC_WGM_PCPWM) || (waveform_gen_mode == ETC_WGM_PCPWMA);
	assign pwm_mode  = fast_mode || pc_mode;
	assign top_val   = waveform_gen_mode[2] ? cmp_a_q : ETC_MAX;
	assign at_bottom = (counter_value_q == ETC_BOTTOM);
	assign at_max    = (counter_value_q == ETC_MAX);
	assign at_top    = (waveform_gen_mode == ETC_WGM_CTC) ? match_a : (counter_value_q == top_val);
	assign match_a   = (counter_value_q == cmp_a_q);
	assign match_b   = (counter_value_q == cmp_b_q);
	assign wr_count  = bus.wr && (bus.addr == ETC_COUNT);
	assign wr_ca     = bus.wr && (bus.addr == ETC_CMP_A);
	assign wr_cb     = bus.wr && (bus.addr == ETC_CMP_B);
	assign force_a   = bus.wr && (bus.addr == ETC_CTRL_B) && bus.wdata[ETC_FOCA_BIT] && !pwm_mode;
	assign force_b   = bus.wr && (bus.addr == ETC_CTRL_B) && bus.wdata[ETC_FOCB_BIT] && !pwm_mode;
	assign eff_a     = timer_tick && match_a && !block_q;
	assign eff_b     = timer_tick && match_b && !block_q;

	// external pin synchroniser, two stages
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ext_s1_q   <= 1'b0;
			ext_s2_q   <= 1'b0;
			ext_prev_q <= 1'b0;
		end else begin
			ext_s1_q   <= ext_clk_pin;
			ext_s2_q   <= ext_s1_q;
			ext_prev_q <= ext_s2_q;
		end
	end

	// clock select: tick source, none when stopped
	always_comb begin
		case (clock_select_field)
			ETC_CS_STOP: timer_tick = 1'b0;
			ETC_CS_EXTF: timer_tick = ext_prev_q && !ext_s2_q;
			ETC_CS_EXTR: timer_tick = !ext_prev_q && ext_s2_q;
			ETC_CS_DIV1: timer_tick = 1'b1;
			default:     timer_tick = presc_tick;
		endcase
	end

	// control registers, masks and pin direction
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_a_q <= ETC_ZERO8;
			ctrl_b_q <= 5'h00;
			mask_q   <= 3'h0;
			pindir_q <= 2'h0;
		end else if (bus.wr) begin
			case (bus.addr)
				ETC_CTRL_A: ctrl_a_q <= bus.wdata;
				ETC_CTRL_B: ctrl_b_q <= bus.wdata[4:0]; // strobes not stored
				ETC_MASK:   mask_q   <= bus.wdata[2:0];
				ETC_PINDIR: pindir_q <= bus.wdata[1:0];
				default:    ;
			endcase
		end
	end

	// direction: phase-correct flips at the ends
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			dir_q <= ETC_DIR_UP;
		end else if (!pc_mode) begin
			dir_q <= ETC_DIR_UP;
		end else if (timer_tick && !wr_count) begin
			if (dir_q == ETC_DIR_UP && counter_value_q == top_val - 8'h01)
				dir_q <= ETC_DIR_DOWN;
			else if (dir_q == ETC_DIR_DOWN && counter_value_q == 8'h01)
				dir_q <= ETC_DIR_UP;
		end
	end

	// counter: write first, then clear, then count
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			counter_value_q <= ETC_ZERO8;
		end else if (wr_count) begin
			counter_value_q <= bus.wdata;
		end else if (timer_tick) begin
			if (!pc_mode && at_top)
				counter_value_q <= ETC_BOTTOM;
			else if (pc_mode && dir_q == ETC_DIR_DOWN) // stale down ignored off phase-correct
				counter_value_q <= counter_value_q - 8'h01;
			else
				counter_value_q <= counter_value_q + 8'h01;
		end
	end

	// match block after a counter write, lasts one tick
	always_ff @(posedge core_clk) begin
		if (!rst_n)
			block_q <= 1'b0;
		else if (wr_count)
			block_q <= 1'b1;
		else if (timer_tick)
			block_q <= 1'b0;
	end

	// compare values, buffered in pwm modes
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cmp_a_q <= ETC_ZERO8;
			cmp_b_q <= ETC_ZERO8;
			buf_a_q <= ETC_ZERO8;
			buf_b_q <= ETC_ZERO8;
		end else begin
			if (wr_ca) buf_a_q <= bus.wdata;
			if (wr_cb) buf_b_q <= bus.wdata;
			if (!pwm_mode) begin // bypass
				if (wr_ca) cmp_a_q <= bus.wdata;
				if (wr_cb) cmp_b_q <= bus.wdata;
			end else if (timer_tick && at_top) begin // top is passed once per period
				cmp_a_q <= buf_a_q; // load at top
				cmp_b_q <= buf_b_q;
			end
		end
	end

	// flags: hardware set beats software clear
	always_ff @(posedge core_clk) begin
		logic [2:0] set_v;
		logic [2:0] clr_v;
		set_v = 3'h0;
		clr_v = {irq_ack_cb, irq_ack_ca, irq_ack_ovf};
		if (bus.wr && bus.addr == ETC_FLAGS)
			clr_v = clr_v | bus.wdata[2:0];
		// overflow point per mode
		if (timer_tick) begin
			if (pc_mode)
				set_v[ETC_FLG_OVF] = at_bottom; // direction already turned here
			else if (fast_mode)
				set_v[ETC_FLG_OVF] = at_top;
			else
				set_v[ETC_FLG_OVF] = at_max && !wr_count;
		end
		set_v[ETC_FLG_CA] = eff_a;
		set_v[ETC_FLG_CB] = eff_b;
		if (!rst_n)
			flags_q <= 3'h0;
		else
			flags_q <= (flags_q & ~clr_v) | set_v;
	end

	// compare output latches, kept across mode change
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			latch_q <= 2'h0;
		end else begin
			if (force_a || (eff_a && !pwm_mode))
				latch_q[0] <= com_next(com_a, latch_q[0]);
			else if (eff_a && fast_mode && com_a[1])
				latch_q[0] <= com_a[0]; // clear or set on match
			else if (eff_a && pc_mode && com_a[1])
				latch_q[0] <= com_a[0] ^ (dir_q == ETC_DIR_DOWN);
			else if (eff_a && pwm_mode && com_a == ETC_COM_TOGGLE && waveform_gen_mode[2])
				latch_q[0] <= ~latch_q[0];
			else if (timer_tick && fast_mode && at_top && com_a[1])
				latch_q[0] <= ~com_a[0]; // opposite level at bottom
			if (force_b || (eff_b && !pwm_mode))
				latch_q[1] <= com_next(com_b, latch_q[1]);
			else if (eff_b && fast_mode && com_b[1])
				latch_q[1] <= com_b[0];
			else if (eff_b && pc_mode && com_b[1])
				latch_q[1] <= com_b[0] ^ (dir_q == ETC_DIR_DOWN);
			else if (timer_tick && fast_mode && at_top && com_b[1])
				latch_q[1] <= ~com_b[0];
		end
	end

	// pin mux: latch replaces port when mode nonzero
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pin_out <= 2'h0;
			pin_oe  <= 2'h0;
		end else begin
			pin_out[0] <= (com_a != ETC_COM_NONE) ? latch_q[0] : port_data[0];
			pin_out[1] <= (com_b != ETC_COM_NONE) ? latch_q[1] : port_data[1];
			pin_oe     <= pindir_q; // direction from compare_pin_direction bits
		end
	end

	// interrupt requests
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_ovf <= 1'b0;
			irq_ca  <= 1'b0;
			irq_cb  <= 1'b0;
		end else begin
			irq_ovf <= flags_q[ETC_FLG_OVF] & mask_q[ETC_FLG_OVF];
			irq_ca  <= flags_q[ETC_FLG_CA] & mask_q[ETC_FLG_CA];
			irq_cb  <= flags_q[ETC_FLG_CB] & mask_q[ETC_FLG_CB];
		end
	end

	// read data, one cycle after strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rdata <= ETC_ZERO8;
		end else if (bus.rd) begin
			case (bus.addr)
				ETC_CTRL_A: rdata <= ctrl_a_q;
				ETC_CTRL_B: rdata <= {3'h0, ctrl_b_q};
				ETC_COUNT:  rdata <= counter_value_q;
				ETC_CMP_A:  rdata <= pwm_mode ? buf_a_q : cmp_a_q;
				ETC_CMP_B:  rdata <= pwm_mode ? buf_b_q : cmp_b_q;
				ETC_MASK:   rdata <= {5'h00, mask_q};
				ETC_FLAGS:  rdata <= {5'h00, flags_q};
				ETC_PINDIR: rdata <= {6'h00, pindir_q};
				default:    rdata <= ETC_ZERO8;
			endcase
		end else begin
			rdata <= ETC_ZERO8;
		end
	end

	// checks
	property p_stop_hold;
		@(posedge core_clk) disable iff (!rst_n)
		(clock_select_field == ETC_CS_STOP && !wr_count) |=> $stable(counter_value_q);
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("counter moved while stopped");

	property p_write_wins;
		@(posedge core_clk) disable iff (!rst_n)
		wr_count |=> counter_value_q == $past(bus.wdata);
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("counter write lost");

	property p_step;
		@(posedge core_clk) disable iff (!rst_n)
		(timer_tick && !wr_count && !at_top && !pc_mode) |=> counter_value_q == $past(counter_value_q) + 8'h01;
	endproperty
	a_step: assert property (p_step) else $error("count step wrong");

	property p_flag_a;
		@(posedge core_clk) disable iff (!rst_n)
		(timer_tick && match_a && !block_q) |=> flags_q[ETC_FLG_CA];
	endproperty
	a_flag_a: assert property (p_flag_a) else $error("compare flag a not set");

	property p_block;
		@(posedge core_clk) disable iff (!rst_n)
		(timer_tick && block_q && !wr_count) |=> (flags_q[2:1] & ~$past(flags_q[2:1])) == 2'b00;
	endproperty
	a_block: assert property (p_block) else $error("flags set despite block");

	property p_clear_flag;
		@(posedge core_clk) disable iff (!rst_n)
		(bus.wr && bus.addr == ETC_FLAGS && bus.wdata[ETC_FLG_CB] && !eff_b) |=> !flags_q[ETC_FLG_CB];
	endproperty
	a_clear_flag: assert property (p_clear_flag) else $error("flag b not cleared");

	property p_irq;
		@(posedge core_clk) disable iff (!rst_n)
		(flags_q[ETC_FLG_CA] && mask_q[ETC_FLG_CA]) |=> irq_ca;
	endproperty
	a_irq: assert property (p_irq) else $error("irq a missing");

	property p_override;
		@(posedge core_clk) disable iff (!rst_n)
		(rst_n && com_b == ETC_COM_NONE) |=> pin_out[1] == $past(port_data[1]);
	endproperty
	a_override: assert property (p_override) else $error("pin b not port value");

	property p_direct;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_ca && !pwm_mode) |=> cmp_a_q == $past(bus.wdata);
	endproperty
	a_direct: assert property (p_direct) else $error("direct compare write lost");

	property p_oe;
		@(posedge core_clk) disable iff (!rst_n)
		rst_n |=> pin_oe == $past(pindir_q);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable not direction bits");

	property p_latch_reset;
		@(posedge core_clk)
		!rst_n |=> latch_q == 2'h0;
	endproperty
	a_latch_reset: assert property (p_latch_reset) else $error("latch not cleared by reset");

	property p_force_flag;
		@(posedge core_clk) disable iff (!rst_n)
		(force_a && !eff_a && !flags_q[ETC_FLG_CA]) |=> !flags_q[ETC_FLG_CA];
	endproperty
	a_force_flag: assert property (p_force_flag) else $error("force set compare flag a");

	property p_force_latch;
		@(posedge core_clk) disable iff (!rst_n)
		(force_a && com_a == ETC_COM_TOGGLE) |=> latch_q[0] != $past(latch_q[0]);
	endproperty
	a_force_latch: assert property (p_force_latch) else $error("force did not toggle latch a");

	property p_mode_keep;
		@(posedge core_clk) disable iff (!rst_n)
		(bus.wr && bus.addr == ETC_CTRL_A && !timer_tick) |=> $stable(latch_q);
	endproperty
	a_mode_keep: assert property (p_mode_keep) else $error("latch moved on mode write");

	property p_ovf_max;
		@(posedge core_clk) disable iff (!rst_n)
		(timer_tick && !wr_count && waveform_gen_mode == ETC_WGM_NORMAL && at_max)
			|=> flags_q[ETC_FLG_OVF];
	endproperty
	a_ovf_max: assert property (p_ovf_max) else $error("overflow flag not set from max");

	property p_com_none;
		@(posedge core_clk) disable iff (!rst_n)
		(eff_a && com_a == ETC_COM_NONE && !force_a) |=> $stable(latch_q[0]);
	endproperty
	a_com_none: assert property (p_com_none) else $error("latch a moved with mode zero");

	property p_ctc_clear;
		@(posedge core_clk) disable iff (!rst_n)
		(timer_tick && !wr_count && waveform_gen_mode == ETC_WGM_CTC && match_a)
			|=> counter_value_q == ETC_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear) else $error("counter not cleared on match");
endmodule : etc_core
`default_nettype wire

// ---- verilog/etc_pkg.sv ----
// Functional notes
// - count steps value by one, per direction
// - clear forces counter to zero
// - each tick clears, increments or decrements
// - clock select zero stops all ticks
// - counter readable and writable at any time
// - counter write beats clear and count
// - three-bit mode split across control A/B
// - overflow flag per mode, interrupt source
// - comparator checks counter against both values
// - match sets flag on following tick
// - flag clears on service or one-write
// - pwm modes double buffer compare values
// - compare writes go to buffer or direct
// - force strobe updates latch only, non-pwm
// - counter write blocks next tick's matches
// - latches keep value across mode change
// - output mode fields take effect immediately
// - output mode sets latch action at match
// - reset clears compare output latches
// - nonzero output mode overrides port pin
// - pin override ignores waveform mode
// - bottom at 0x00, max at 0xFF
// - output mode zero means no action
package etc_pkg;
	// register indices on the plain port
	localparam logic [3:0] ETC_CTRL_A  = 4'h0; // modes low bits, output modes
	localparam logic [3:0] ETC_CTRL_B  = 4'h1; // force strobes, mode bit2, clock select
	localparam logic [3:0] ETC_COUNT   = 4'h2; // counter_value
	localparam logic [3:0] ETC_CMP_A   = 4'h3; // compare_value_a
	localparam logic [3:0] ETC_CMP_B   = 4'h4; // compare_value_b
	localparam logic [3:0] ETC_MASK    = 4'h5; // interrupt masks
	localparam logic [3:0] ETC_FLAGS   = 4'h6; // flags, write one clears
	localparam logic [3:0] ETC_PINDIR  = 4'h7; // compare_pin_direction
	// field positions
	localparam int ETC_COMA_LSB = 6; // compare_output_mode a in ctrl a
	localparam int ETC_COMB_LSB = 4; // compare_output_mode b in ctrl a
	localparam int ETC_WGM_LSB  = 0; // waveform_gen_mode bits 1:0 in ctrl a
	localparam int ETC_FOCA_BIT = 7; // force strobe a in ctrl b
	localparam int ETC_FOCB_BIT = 6; // force strobe b in ctrl b
	localparam int ETC_WGM2_BIT = 3; // waveform_gen_mode bit2 in ctrl b
	localparam int ETC_CS_LSB   = 0; // clock_select_field in ctrl b
	localparam int ETC_FLG_OVF  = 0; // overflow flag bit
	localparam int ETC_FLG_CA   = 1; // compare flag a bit
	localparam int ETC_FLG_CB   = 2; // compare flag b bit
	// counter extremes and reset values
	localparam logic [7:0] ETC_BOTTOM = 8'h00;
	localparam logic [7:0] ETC_MAX    = 8'hFF;
	localparam logic [7:0] ETC_ZERO8  = 8'h00;
	// clock select encodings
	localparam logic [2:0] ETC_CS_STOP = 3'h0;
	localparam logic [2:0] ETC_CS_DIV1 = 3'h1;
	localparam logic [2:0] ETC_CS_EXTF = 3'h6;
	localparam logic [2:0] ETC_CS_EXTR = 3'h7;
	// waveform modes
	localparam logic [2:0] ETC_WGM_NORMAL = 3'h0;
	localparam logic [2:0] ETC_WGM_PCPWM  = 3'h1;
	localparam logic [2:0] ETC_WGM_CTC    = 3'h2;
	localparam logic [2:0] ETC_WGM_FPWM   = 3'h3;
	localparam logic [2:0] ETC_WGM_PCPWMA = 3'h5;
	localparam logic [2:0] ETC_WGM_FPWMA  = 3'h7;
	// compare output mode encodings
	localparam logic [1:0] ETC_COM_NONE   = 2'h0;
	localparam logic [1:0] ETC_COM_TOGGLE = 2'h1;
	localparam logic [1:0] ETC_COM_CLEAR  = 2'h2;
	localparam logic [1:0] ETC_COM_SET    = 2'h3;
	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} etc_bus_t;
	// count direction states, one-hot
	typedef enum logic [1:0] {
		ETC_DIR_UP   = 2'b01,
		ETC_DIR_DOWN = 2'b10
	} etc_dir_t;
endpackage : etc_pkg
